// [src/rri_exec_map.vh]
// Constants for the return and rotate instruction execution block.
`ifndef RRI_EXEC_MAP_VH
`define RRI_EXEC_MAP_VH
`define RRI_OP_NONE 3'h0
`define RRI_OP_RET_IRQ 3'h1
`define RRI_OP_RET_SUB 3'h2
`define RRI_OP_RET_LIT 3'h3
`define RRI_OP_ROT_LEFT 3'h4
`define RRI_GIE_BIT 7
`define RRI_INTCTL_RESET 8'h00
`define RRI_ACC_RESET 8'h00
`define RRI_CARRY_RESET 1'b0
`define RRI_PC_RESET 13'h0000
`define RRI_STACK_DEPTH 8
`define RRI_STACK_PTR_W 3
`define RRI_PC_W 13
`define RRI_RET_CYCLES 2'h2
`endif

// [src/rri_rotate.v]
// Rotate-left-through-carry datapath.
`default_nettype none
module rri_rotate (
  input wire [7:0] operand_in,
  input wire carry_in,
  output wire [7:0] result_out,
  output wire carry_out
);
  // [RQ11] carry in, msb out
  assign result_out = {operand_in[6:0], carry_in};
  assign carry_out = operand_in[7];
endmodule
`default_nettype wire

// [src/rri_exec.v]
// Execution of return, return-from-interrupt, return-literal and rotate-left.
// Functional notes
// [RQ1] Return-from-interrupt pops the return stack into the program counter.
// [RQ2] Return-from-interrupt sets the global interrupt enable, bit 7.
// [RQ3] Return-from-interrupt is one word, two cycles, flags untouched.
// [RQ4] Return pops the stack into the program counter, flags untouched.
// [RQ5] Return takes two instruction cycles.
// [RQ6] Return-with-literal loads its 8-bit literal into the accumulator.
// [RQ7] Return-with-literal reloads the program counter, in two cycles.
// [RQ8] Rotate-left shifts file register 0..127 left through carry only.
// [RQ9] Rotate-left with destination 0 writes the accumulator only.
// [RQ10] Rotate-left with destination 1 writes the file register back.
// [RQ11] Rotate-left moves old carry into bit 0 and bit 7 into carry.
`include "rri_exec_map.vh"
`default_nettype none
module rri_exec (
  input wire clock_in,
  input wire sys_rst_in,
  input wire op_valid_in,
  input wire [2:0] op_code_in,
  input wire [7:0] literal_in,
  input wire [6:0] file_addr_in,
  input wire dest_sel_in,
  input wire [7:0] file_rdata_in,
  input wire push_in,
  input wire [12:0] push_addr_in,
  output reg busy_out,
  output reg [12:0] pc_out,
  output reg pc_load_out,
  output reg [7:0] acc_out,
  output reg carry_out,
  output reg [7:0] interrupt_control_reg_out,
  output reg file_we_out,
  output reg [6:0] file_waddr_out,
  output reg [7:0] file_wdata_out,
  output reg [2:0] stack_ptr_out
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SECOND = 1'b1;

  // Opcodes that finish with a stack pop in their second cycle.
  function is_return;
    input [2:0] code;
    begin
      is_return = (code == `RRI_OP_RET_IRQ) ||
        (code == `RRI_OP_RET_SUB) || (code == `RRI_OP_RET_LIT);
    end
  endfunction

  function is_rotate;
    input [2:0] code;
    begin
      is_rotate = (code == `RRI_OP_ROT_LEFT);
    end
  endfunction

  // Sets the global enable and leaves the other control bits alone.
  function [7:0] with_gie;
    input [7:0] ctl;
    begin
      with_gie = ctl;
      with_gie[`RRI_GIE_BIT] = 1'b1;
    end
  endfunction

  reg state_q;
  reg state_d;
  reg [2:0] pend_op_q;
  reg [2:0] pend_op_d;

  reg busy_d;
  reg [12:0] pc_d;
  reg pc_load_d;
  reg [7:0] acc_d;
  reg carry_d;
  reg [7:0] intctl_d;
  reg file_we_d;
  reg [6:0] file_waddr_d;
  reg [7:0] file_wdata_d;
  reg [2:0] stack_ptr_d;
  reg push_we;

  wire [12:0] stack_word [0:`RRI_STACK_DEPTH-1];
  wire [`RRI_STACK_DEPTH-1:0] push_sel;
  wire [12:0] pop_addr;
  wire [2:0] top_idx;
  wire [7:0] rot_res;
  wire rot_carry;
  wire take;
  wire take_ret;
  wire take_rot;
  wire take_push;
  genvar g;

  assign top_idx = stack_ptr_out - 3'h1;
  assign pop_addr = stack_word[top_idx];
  assign take = op_valid_in && !busy_out;
  assign take_ret = take && is_return(op_code_in);
  assign take_rot = take && is_rotate(op_code_in);
  // An unknown opcode is still taken, so it also blocks a push.
  assign take_push = push_in && !take;
  assign push_sel = push_we ? (8'h01 << stack_ptr_out) : 8'h00;

  rri_rotate u_rot (
    .operand_in(file_rdata_in),
    .carry_in(carry_out),
    .result_out(rot_res),
    .carry_out(rot_carry)
  );

  // One register per return-stack slot, written only when selected.
  // A pop does not clear its slot, so an unbalanced return reads a
  // stale address; the caller keeps pushes and returns paired.
  generate
    for (g = 0; g < `RRI_STACK_DEPTH; g = g + 1) begin : g_slot
      reg [12:0] slot_q;
      always @(posedge clock_in) begin
        if (sys_rst_in) begin
          slot_q <= `RRI_PC_RESET;
        end else if (push_sel[g]) begin
          slot_q <= push_addr_in;
        end
      end
      assign stack_word[g] = slot_q;
    end
  endgenerate

  // Next values; every output except pc_load_out and file_we_out holds unless a branch below changes it.
  always @* begin
    state_d = state_q;
    pend_op_d = pend_op_q;
    busy_d = busy_out;
    pc_d = pc_out;
    pc_load_d = 1'b0;
    acc_d = acc_out;
    carry_d = carry_out;
    intctl_d = interrupt_control_reg_out;
    file_we_d = 1'b0;
    file_waddr_d = file_waddr_out;
    file_wdata_d = file_wdata_out;
    stack_ptr_d = stack_ptr_out;
    push_we = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take_ret) begin
          // [RQ5] two-cycle returns
          state_d = ST_SECOND;
          busy_d = 1'b1;
          pend_op_d = op_code_in;
          // [RQ6] literal into accumulator
          if (op_code_in == `RRI_OP_RET_LIT) begin
            acc_d = literal_in;
          end
        end else if (take_rot) begin
          // [RQ8] only carry flag changes
          carry_d = rot_carry;
          // [RQ9] destination zero to accumulator
          if (!dest_sel_in) begin
            acc_d = rot_res;
          end else begin
            // [RQ10] destination one writes back
            file_we_d = 1'b1;
            file_waddr_d = file_addr_in;
            file_wdata_d = rot_res;
          end
        end else if (take_push) begin
          push_we = 1'b1;
          stack_ptr_d = stack_ptr_out + 3'h1;
        end
      end
      ST_SECOND: begin
        // [RQ1] [RQ4] [RQ7] pop into program counter
        pc_d = pop_addr;
        pc_load_d = 1'b1;
        stack_ptr_d = top_idx;
        // [RQ2] set global interrupt enable
        if (pend_op_q == `RRI_OP_RET_IRQ) begin
          intctl_d = with_gie(interrupt_control_reg_out);
        end
        // [RQ3] done after second cycle, flags untouched
        state_d = ST_IDLE;
        busy_d = 1'b0;
        pend_op_d = `RRI_OP_NONE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencing registers.
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      pend_op_q <= `RRI_OP_NONE;
      busy_out <= 1'b0;
      stack_ptr_out <= 3'h0;
    end else begin
      state_q <= state_d;
      pend_op_q <= pend_op_d;
      busy_out <= busy_d;
      stack_ptr_out <= stack_ptr_d;
    end
  end

  // Datapath outputs, each one a flip-flop.
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      pc_out <= `RRI_PC_RESET;
      pc_load_out <= 1'b0;
      acc_out <= `RRI_ACC_RESET;
      carry_out <= `RRI_CARRY_RESET;
      interrupt_control_reg_out <= `RRI_INTCTL_RESET;
      file_we_out <= 1'b0;
      file_waddr_out <= 7'h00;
      file_wdata_out <= 8'h00;
    end else begin
      pc_out <= pc_d;
      pc_load_out <= pc_load_d;
      acc_out <= acc_d;
      carry_out <= carry_d;
      interrupt_control_reg_out <= intctl_d;
      file_we_out <= file_we_d;
      file_waddr_out <= file_waddr_d;
      file_wdata_out <= file_wdata_d;
    end
  end
endmodule
`default_nettype wire

// [tb/rri_exec_properties.sv]
// Checker for the return and rotate execution block.
`include "rri_exec_map.vh"
`default_nettype none
module rri_exec_properties (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [7:0] literal_in,
  input wire logic dest_sel_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic busy_out,
  input wire logic pc_load_out,
  input wire logic [7:0] acc_out,
  input wire logic carry_out,
  input wire logic [7:0] interrupt_control_reg_out,
  input wire logic file_we_out,
  input wire logic [7:0] file_wdata_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire tk = op_valid_in && !busy_out;
  wire rot = tk && op_code_in == `RRI_OP_ROT_LEFT;
  wire irq = tk && op_code_in == `RRI_OP_RET_IRQ;
  wire lit = tk && op_code_in == `RRI_OP_RET_LIT;
  wire ret = irq || lit || tk && op_code_in == `RRI_OP_RET_SUB;
  // Expected rotate result, one cycle behind the operands.
  logic [7:0] rr;
  always_ff @(posedge clock_in) rr <= {file_rdata_in[6:0], carry_out};
  sequence s_ret;
    busy_out ##1 (!busy_out && pc_load_out);
  endsequence
  AST_RET_TIME: assert property (ret |=> s_ret)
    else $error("return timing wrong");
  AST_GIE_SET: assert property (irq |=> ##1 interrupt_control_reg_out[7])
    else $error("global enable not set");
  AST_RET_FLAGS: assert property (ret |=> $stable(carry_out) [*2])
    else $error("carry changed by return");
  AST_LIT_ACC: assert property (lit |=> acc_out == $past(literal_in))
    else $error("literal not loaded");
  AST_ROT_CARRY: assert property (
    rot |=> carry_out == $past(file_rdata_in[7]))
    else $error("rotate carry wrong");
  AST_ROT_ACC: assert property (
    rot && !dest_sel_in |=> acc_out == rr && !file_we_out)
    else $error("rotate to accumulator wrong");
  AST_ROT_FILE: assert property (
    rot && dest_sel_in |=> file_we_out && file_wdata_out == rr)
    else $error("rotate to file wrong");
  AST_ROT_KEEP: assert property (
    rot && dest_sel_in |=> $stable(acc_out))
    else $error("accumulator changed");
endmodule
bind rri_exec rri_exec_properties u_props (
  .clock_in(clock_in),
  .sys_rst_in(sys_rst_in),
  .op_valid_in(op_valid_in),
  .op_code_in(op_code_in),
  .literal_in(literal_in),
  .dest_sel_in(dest_sel_in),
  .file_rdata_in(file_rdata_in),
  .busy_out(busy_out),
  .pc_load_out(pc_load_out),
  .acc_out(acc_out),
  .carry_out(carry_out),
  .interrupt_control_reg_out(interrupt_control_reg_out),
  .file_we_out(file_we_out),
  .file_wdata_out(file_wdata_out)
);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the return and rotate execution block.
`include "rri_exec_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, sys_rst_in = 1, op_valid_in = 0, dest_sel_in = 0;
  logic push_in = 0, exp_c = 0;
  logic [2:0] op_code_in = 0;
  logic [7:0] literal_in = 0, file_rdata_in = 0, exp_a = 0;
  logic [6:0] file_addr_in = 0;
  logic [12:0] push_addr_in = 0;
  wire busy_out, pc_load_out, carry_out, file_we_out;
  wire [12:0] pc_out;
  wire [7:0] acc_out, interrupt_control_reg_out, file_wdata_out;
  wire [6:0] file_waddr_out;
  wire [2:0] stack_ptr_out;
  int mismatches = 0, num_checks = 0;
  rri_exec DUT (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .op_valid_in(op_valid_in),
    .op_code_in(op_code_in),
    .literal_in(literal_in),
    .file_addr_in(file_addr_in),
    .dest_sel_in(dest_sel_in),
    .file_rdata_in(file_rdata_in),
    .push_in(push_in),
    .push_addr_in(push_addr_in),
    .busy_out(busy_out),
    .pc_out(pc_out),
    .pc_load_out(pc_load_out),
    .acc_out(acc_out),
    .carry_out(carry_out),
    .interrupt_control_reg_out(interrupt_control_reg_out),
    .file_we_out(file_we_out),
    .file_waddr_out(file_waddr_out),
    .file_wdata_out(file_wdata_out),
    .stack_ptr_out(stack_ptr_out)
  );
  initial forever #20 clock_in = ~clock_in;
  task automatic tick;
    @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // With keep set, valid stays high for the caller's next request.
  task automatic op(input logic [2:0] c, input logic d, input logic [7:0] v,
                    input logic keep);
    op_code_in = c;
    dest_sel_in = d;
    literal_in = v;
    file_rdata_in = v;
    file_addr_in = 7'h7f;
    op_valid_in = 1;
    tick;
    if (!keep) op_valid_in = 0;
  endtask
  task automatic test_rot(input logic d, input logic [7:0] v);
    logic [7:0] r;
    r = {v[6:0], exp_c};
    exp_c = v[7];
    if (!d) exp_a = r;
    op(`RRI_OP_ROT_LEFT, d, v, 0);
    chk(carry_out === exp_c, "carry");
    chk(acc_out === exp_a, "acc");
    chk(file_we_out === d, "we");
    if (d) chk(file_wdata_out === r && file_waddr_out === 7'h7f, "wr");
    tick;
    $display("rotate test done");
  endtask
  task automatic test_ignored;
    push_in = 1;
    push_addr_in = 13'h0123;
    op(3'h5, 1, 8'hff, 0);
    push_in = 0;
    chk(stack_ptr_out === 3'h0 && !busy_out, "push refused");
    chk(acc_out === exp_a && carry_out === exp_c, "no effect");
    chk(file_we_out === 1'b0 && pc_load_out === 1'b0, "no write");
    tick;
    $display("ignored opcode test done");
  endtask
  task automatic test_ret(input logic [2:0] c, input logic [12:0] a);
    logic [7:0] ic;
    ic = (c == `RRI_OP_RET_IRQ) ? 8'h80 : 8'h00;
    push_in = 1;
    push_addr_in = a;
    tick;
    push_in = 0;
    chk(stack_ptr_out === 3'h1, "push");
    if (c == `RRI_OP_RET_LIT) exp_a = 8'hc3;
    op(c, 0, 8'hc3, 1);
    chk(busy_out === 1'b1, "busy");
    // Valid stays high into the busy cycle; that request must be ignored.
    op(c, 0, 8'h11, 0);
    chk(pc_load_out === 1'b1 && pc_out === a, "pc");
    chk(acc_out === exp_a && carry_out === exp_c, "flags");
    chk(interrupt_control_reg_out === ic, "gie");
    tick;
    chk(!busy_out && !pc_load_out && stack_ptr_out === 3'h0, "idle");
    $display("return test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock_in);
    #1 sys_rst_in = 0;
    test_rot(0, 8'he6);
    test_rot(1, 8'h01);
    test_rot(1, 8'h80);
    test_ignored;
    test_ret(`RRI_OP_RET_SUB, 13'h1fff);
    test_ret(`RRI_OP_RET_LIT, 13'h0abc);
    test_ret(`RRI_OP_RET_IRQ, 13'h0001);
    end_of_test;
  end
endmodule
`default_nettype wire
